// *** logic/ftpu_defs.svh ***
`ifndef FTPU_DEFS_SVH
`define FTPU_DEFS_SVH

// ==========================================================================
// Register offsets
`define FTPU_OFS_CTRL 8'h00
`define FTPU_OFS_DELAY 8'h04
`define FTPU_OFS_DUR 8'h08
`define FTPU_OFS_HIGH 8'h0c
`define FTPU_OFS_CHCFG 8'h10
`define FTPU_OFS_USER 8'h14
`define FTPU_OFS_STAT 8'h18

// ==========================================================================
// Field positions
`define FTPU_CTRL_PULSED 0
`define FTPU_CTRL_ACT_HIGH 1
`define FTPU_CTRL_RISING 2
`define FTPU_CH_FIELD_W 4
`define FTPU_CH_FAST_LSB 12
`define FTPU_STAT_ERR_LSB 8

// ==========================================================================
// Reset values
`define FTPU_CTRL_RST 3'h6
`define FTPU_CHCFG_RST 12'h290
`define FTPU_DELAY_RST 33'h0
`define FTPU_DUR_RST 33'h32

// ==========================================================================
// Timing
`define FTPU_CLK_NS 8
`define FTPU_TICK_NS 20
`define FTPU_GREEN_MS 10
`define FTPU_PULSE_MIN_US 1
`define FTPU_PULSE_MAX_S 85

`endif

// *** logic/ftpu_pkg.sv ***
package ftpu_pkg;

    // ======================================================================
    // Types
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE} ftpu_state_t;
    typedef enum logic [1:0] {SRC_FAULT, SRC_SYNC, SRC_USER, SRC_NONE} ftpu_src_t;
    typedef enum logic [1:0] {DRV_SINK, DRV_SOURCE, DRV_PUSHPULL, DRV_OFF} ftpu_drive_t;

endpackage

// *** logic/ftpu_trig_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface ftpu_trig_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

`default_nettype wire

// *** logic/ftpu_sync_edge.sv ***
`timescale 1ns/1ps
`default_nettype none

module ftpu_sync_edge (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_in,
    ftpu_trig_if.src trig
);

    logic [2:0] stg_q;
    logic [2:0] stg_d;

    // ======================================================================
    // Synchroniser and edge detector
    always_comb begin
        stg_d = {stg_q[1:0], pin_in};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stg_q <= 3'h0;
        end else begin
            stg_q <= stg_d;
        end
    end

    // Stage zero is read only by stage one; edges compare stages one and two.
    assign trig.level = stg_q[1];
    assign trig.rise = stg_q[1] & ~stg_q[2];
    assign trig.fall = ~stg_q[1] & stg_q[2];

    // ======================================================================
    // Checks
    sync_rise_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pin_in) ##1 pin_in |-> ##1 trig.rise)
        else $error("rise not seen two cycles after input");

endmodule

`default_nettype wire

// *** logic/ftpu_chan_drv.sv ***
`timescale 1ns/1ps
`default_nettype none

module ftpu_chan_drv #(
    parameter bit FAST_OK = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic active,
    input wire ftpu_pkg::ftpu_drive_t drive,
    input wire logic fast,
    output logic hi_q,
    output logic lo_q
);

    logic fast_eff;
    logic hi_d;
    logic lo_d;

    // ======================================================================
    // Driver stage selection
    assign fast_eff = FAST_OK & fast;

    always_comb begin
        hi_d = 1'b0;
        lo_d = 1'b0;
        if (fast_eff) begin
            // Low-latency drive pulls the pin low while the signal is active.
            lo_d = active;
        end else begin
            case (drive)
                ftpu_pkg::DRV_SINK: lo_d = active;
                ftpu_pkg::DRV_SOURCE: hi_d = active;
                ftpu_pkg::DRV_PUSHPULL: begin
                    hi_d = active;
                    lo_d = ~active;
                end
                default: hi_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
        end
    end

    // ======================================================================
    // Checks
    fast_sink_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        fast_eff |=> !hi_q)
        else $error("high side on in low-latency drive");
    fast_active_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        fast_eff && active |=> lo_q)
        else $error("pin not pulled low during active signal");

endmodule

`default_nettype wire

// *** logic/ftpu_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ftpu_defs.svh"

module ftpu_top #(
    parameter int GREEN_CYCLES = `FTPU_GREEN_MS * 1000000 / `FTPU_CLK_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sync_in,
    input wire logic supply_fault,
    input wire logic [2:0] chan_fault,
    input wire logic [2:0] chan_sense,
    output logic lamp_on,
    output logic fault_active,
    output logic status_red,
    output logic trig_led_green,
    output logic trig_led_yellow,
    output logic [2:0] chan_drive_hi,
    output logic [2:0] chan_drive_lo
);

    localparam int CNT_W = 33;
    localparam int GW = $clog2(GREEN_CYCLES + 1);
    localparam logic [CNT_W-1:0] DUR_MIN =
        CNT_W'((`FTPU_PULSE_MIN_US * 1000 + `FTPU_TICK_NS - 1) / `FTPU_TICK_NS);
    localparam logic [CNT_W-1:0] DUR_MAX =
        CNT_W'(64'd1000000000 * `FTPU_PULSE_MAX_S / `FTPU_TICK_NS);
    localparam logic [5:0] TICK_STEP = 6'(`FTPU_CLK_NS);
    localparam logic [5:0] TICK_MOD = 6'(`FTPU_TICK_NS);
    localparam logic [GW-1:0] GREEN_LOAD = GW'(GREEN_CYCLES);

    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ======================================================================
    // Input synchroniser
    ftpu_trig_if trig ();

    ftpu_sync_edge u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(sync_in),
        .trig(trig)
    );

    // ======================================================================
    // Wishbone slave and configuration registers
    logic req;
    logic wr;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] rd_word;
    logic [31:0] new_word;
    logic [2:0] ctrl_q, ctrl_d;
    logic [CNT_W-1:0] delay_q, delay_d;
    logic [CNT_W-1:0] dur_q, dur_d;
    logic [11:0] chcfg_q, chcfg_d;
    logic fast_q, fast_d;
    logic [2:0] user_q, user_d;
    logic fault_q;
    logic lamp_q;
    logic [3:0] err_q;
    ftpu_pkg::ftpu_state_t st_q;

    assign req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge at which the master samples the acknowledge.
    assign wr = req & wb_we_i & ack_q;

    always_comb begin
        case (wb_adr_i)
            `FTPU_OFS_CTRL: rd_word = {29'h0, ctrl_q};
            `FTPU_OFS_DELAY: rd_word = delay_q[31:0];
            `FTPU_OFS_DUR: rd_word = dur_q[31:0];
            `FTPU_OFS_HIGH: rd_word = {30'h0, dur_q[CNT_W-1], delay_q[CNT_W-1]};
            `FTPU_OFS_CHCFG: rd_word = {18'h0, fast_q, 1'b0, chcfg_q};
            `FTPU_OFS_USER: rd_word = {29'h0, user_q};
            `FTPU_OFS_STAT: rd_word = {20'h0, err_q, 2'h0, st_q != ftpu_pkg::ST_IDLE,
                                       lamp_q, fault_q, chan_sense};
            default: rd_word = 32'h0;
        endcase
        new_word = wb_merge(rd_word, wb_dat_i, wb_sel_i);
        ack_d = req & ~ack_q;
        rdata_d = (req & ~ack_q) ? rd_word : rdata_q;
        ctrl_d = ctrl_q;
        delay_d = delay_q;
        dur_d = dur_q;
        chcfg_d = chcfg_q;
        fast_d = fast_q;
        user_d = user_q;
        if (wr) begin
            case (wb_adr_i)
                `FTPU_OFS_CTRL: ctrl_d = new_word[2:0];
                `FTPU_OFS_DELAY: delay_d[31:0] = new_word;
                `FTPU_OFS_DUR: dur_d[31:0] = new_word;
                `FTPU_OFS_HIGH: begin
                    delay_d[CNT_W-1] = new_word[0];
                    dur_d[CNT_W-1] = new_word[1];
                end
                `FTPU_OFS_CHCFG: begin
                    chcfg_d = new_word[11:0];
                    // Only the channel two bit is kept; the other two read back zero.
                    fast_d = new_word[`FTPU_CH_FAST_LSB + 1];
                end
                `FTPU_OFS_USER: user_d = new_word[2:0];
                default: ctrl_d = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            ctrl_q <= `FTPU_CTRL_RST;
            delay_q <= `FTPU_DELAY_RST;
            dur_q <= `FTPU_DUR_RST;
            chcfg_q <= `FTPU_CHCFG_RST;
            fast_q <= 1'b0;
            user_q <= 3'h0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            delay_q <= delay_d;
            dur_q <= dur_d;
            chcfg_q <= chcfg_d;
            fast_q <= fast_d;
            user_q <= user_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ======================================================================
    // Fault monitor
    logic fault_d;
    logic [3:0] err_d;

    always_comb begin
        err_d = {chan_fault, supply_fault};
        fault_d = |err_d;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
            err_q <= 4'h0;
        end else begin
            fault_q <= fault_d;
            err_q <= err_d;
        end
    end

    assign fault_active = fault_q;
    assign status_red = fault_q;

    // ======================================================================
    // Pulse timer
    logic pulsed;
    logic trig_act;
    logic acc_edge;
    logic start;
    logic tick;
    logic sync_pulse;
    logic [5:0] acc_sum;
    logic [4:0] acc_q, acc_d;
    logic [CNT_W-1:0] dur_eff;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [GW-1:0] green_q, green_d;
    ftpu_pkg::ftpu_state_t st_d;
    logic lamp_d, led_g_q, led_g_d, led_y_q, led_y_d;

    assign pulsed = ctrl_q[`FTPU_CTRL_PULSED];
    assign trig_act = trig.level == ctrl_q[`FTPU_CTRL_ACT_HIGH];
    assign acc_edge = ctrl_q[`FTPU_CTRL_RISING] ? trig.rise : trig.fall;
    assign start = pulsed & acc_edge & ~fault_q & (st_q == ftpu_pkg::ST_IDLE);
    assign sync_pulse = st_q == ftpu_pkg::ST_PULSE;
    // The 20 ns step is built from 8 ns clocks by a fractional accumulator.
    assign acc_sum = {1'b0, acc_q} + TICK_STEP;
    assign tick = acc_sum >= TICK_MOD;
    assign dur_eff = (dur_q < DUR_MIN) ? DUR_MIN : ((dur_q > DUR_MAX) ? DUR_MAX : dur_q);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        acc_d = tick ? 5'(acc_sum - TICK_MOD) : acc_sum[4:0];
        green_d = (green_q != '0) ? green_q - GW'(1) : green_q;
        if (fault_q || !pulsed) begin
            st_d = ftpu_pkg::ST_IDLE;
        end else begin
            case (st_q)
                ftpu_pkg::ST_IDLE: begin
                    if (start) begin
                        acc_d = 5'h0;
                        green_d = GREEN_LOAD;
                        if (delay_q == '0) begin
                            st_d = ftpu_pkg::ST_PULSE;
                            cnt_d = dur_eff;
                        end else begin
                            st_d = ftpu_pkg::ST_DELAY;
                            cnt_d = delay_q;
                        end
                    end
                end
                ftpu_pkg::ST_DELAY: begin
                    if (tick) begin
                        if (cnt_q == CNT_W'(1)) begin
                            st_d = ftpu_pkg::ST_PULSE;
                            cnt_d = dur_eff;
                        end else begin
                            cnt_d = cnt_q - CNT_W'(1);
                        end
                    end
                end
                ftpu_pkg::ST_PULSE: begin
                    if (tick) begin
                        if (cnt_q == CNT_W'(1)) begin
                            st_d = ftpu_pkg::ST_IDLE;
                        end else begin
                            cnt_d = cnt_q - CNT_W'(1);
                        end
                    end
                end
                default: st_d = ftpu_pkg::ST_IDLE;
            endcase
        end
        lamp_d = ~fault_q & (pulsed ? (st_d == ftpu_pkg::ST_PULSE) : trig_act);
        led_g_d = pulsed ? (green_d != '0) : (trig_act & ~fault_q);
        led_y_d = pulsed & (st_d != ftpu_pkg::ST_IDLE) & (green_d == '0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ftpu_pkg::ST_IDLE;
            cnt_q <= '0;
            acc_q <= 5'h0;
            green_q <= '0;
            lamp_q <= 1'b0;
            led_g_q <= 1'b0;
            led_y_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            green_q <= green_d;
            lamp_q <= lamp_d;
            led_g_q <= led_g_d;
            led_y_q <= led_y_d;
        end
    end

    assign lamp_on = lamp_q;
    assign trig_led_green = led_g_q;
    assign trig_led_yellow = led_y_q;

    // ======================================================================
    // Output channels
    for (genvar i = 0; i < 3; i++) begin : g_ch
        ftpu_pkg::ftpu_src_t src;
        ftpu_pkg::ftpu_drive_t drv;
        logic act;

        assign src = ftpu_pkg::ftpu_src_t'(chcfg_q[i*`FTPU_CH_FIELD_W +: 2]);
        assign drv = ftpu_pkg::ftpu_drive_t'(chcfg_q[i*`FTPU_CH_FIELD_W + 2 +: 2]);

        always_comb begin
            case (src)
                ftpu_pkg::SRC_FAULT: act = fault_q;
                ftpu_pkg::SRC_SYNC: act = sync_pulse;
                ftpu_pkg::SRC_USER: act = user_q[i];
                default: act = 1'b0;
            endcase
        end

        ftpu_chan_drv #(.FAST_OK(i == 1)) u_drv (
            .clk(clk),
            .rst_n(rst_n),
            .active(act),
            .drive(drv),
            .fast(fast_q),
            .hi_q(chan_drive_hi[i]),
            .lo_q(chan_drive_lo[i])
        );
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_start;
        start;
    endsequence

    static_lamp_a: assert property (!pulsed && !fault_q |=> lamp_on == $past(trig_act))
        else $error("static lamp does not follow input");
    edge_start_a: assert property (s_start |=> st_q != ftpu_pkg::ST_IDLE)
        else $error("accepted edge did not start timer");
    wrong_edge_a: assert property (pulsed && !fault_q && st_q == ftpu_pkg::ST_IDLE
        && (ctrl_q[`FTPU_CTRL_RISING] ? trig.fall : trig.rise) |=> st_q == ftpu_pkg::ST_IDLE)
        else $error("wrong edge started timer");
    one_flash_a: assert property (sync_pulse ##1 !sync_pulse |-> st_q == ftpu_pkg::ST_IDLE)
        else $error("second flash without trigger");
    delay_hold_a: assert property (s_start ##0 delay_q > CNT_W'(1)
        |=> (st_q == ftpu_pkg::ST_DELAY) [*2])
        else $error("delay skipped");
    min_pulse_a: assert property ($rose(sync_pulse) |-> (sync_pulse || fault_q) [*8])
        else $error("pulse shorter than minimum");
    tick_space_a: assert property (tick |=> !tick)
        else $error("timer step faster than 20 ns");
    reset_cfg_a: assert property ($rose(rst_n) |-> chcfg_q == `FTPU_CHCFG_RST && !fast_q)
        else $error("channel defaults wrong after reset");
    chan_fault_a: assert property (|chan_fault |=> status_red && err_q[3:1] != 3'h0)
        else $error("channel fault not reported");
    fault_dark_a: assert property (fault_q |=> !lamp_on)
        else $error("lamp on during error");
    fault_clear_a: assert property (!supply_fault && chan_fault == 3'h0 |=> !fault_active)
        else $error("fault output stuck after recovery");
    supply_err_a: assert property (supply_fault |=> fault_active && err_q[0])
        else $error("supply fault not reported");
    no_retrig_a: assert property (sync_pulse && !tick && !fault_q
        |=> cnt_q == $past(cnt_q))
        else $error("pulse timer disturbed during flash");
    green_hold_a: assert property (s_start |=> trig_led_green [*8])
        else $error("green indicator not held");
    zero_delay_a: assert property (s_start ##0 delay_q == '0 |=> sync_pulse)
        else $error("zero delay pulse late");

endmodule

`default_nettype wire

// *** sim/ftpu_trig_src.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Trigger source and output channel load
module ftpu_trig_src #(
    parameter int PIN_CYC = 125
) (
    input wire logic clk,
    input wire logic fire,
    input wire logic idle_lvl,
    input wire logic [2:0] drv_hi,
    input wire logic [2:0] drv_lo,
    output logic sync_pin,
    output logic [2:0] sense
);
    int cnt_q = 0;

    // The pin stays active for 1 us, the shortest pulse a source may give.
    always_ff @(posedge clk) begin
        if (fire) begin
            cnt_q <= PIN_CYC;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end

    assign sync_pin = idle_lvl ^ (cnt_q != 0);
    // A released channel is pulled low by its load.
    assign sense = drv_hi & ~drv_lo;
endmodule

`default_nettype wire

// *** sim/ftpu_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ftpu_defs.svh"

module ftpu_top_tb;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, fire = 0, idle_lvl = 0;
    logic supply_fault = 0, sync_pin, lamp_on, fault_active, status_red, green, yellow, ack;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, dat_o, rdat;
    logic [2:0] chan_fault = 0, sense, hi, lo;
    int mismatches = 0, total_checks = 0, n, w;

    ftpu_top #(.GREEN_CYCLES(20)) u_ftpu_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .sync_in(sync_pin), .supply_fault(supply_fault),
        .chan_fault(chan_fault), .chan_sense(sense), .lamp_on(lamp_on),
        .fault_active(fault_active), .status_red(status_red), .trig_led_green(green),
        .trig_led_yellow(yellow), .chan_drive_hi(hi), .chan_drive_lo(lo));
    ftpu_trig_src u_ftpu_trig_src (.clk(clk), .fire(fire), .idle_lvl(idle_lvl), .drv_hi(hi),
        .drv_lo(lo), .sync_pin(sync_pin), .sense(sense));

    initial begin
        forever #4 clk = ~clk;
    end

    // ======================================================================
    // Shared tasks
    task automatic test_done();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_en;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 100);
        if (k >= 100) mismatches++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_lamp(input logic v, output int c);
        c = 0;
        while (lamp_on !== v && c < 3000) begin
            @(posedge clk);
            c++;
        end
    endtask

    task automatic trig(output int c);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        wait_lamp(1'b1, c);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] a_t[7] = '{`FTPU_OFS_CTRL, `FTPU_OFS_DELAY, `FTPU_OFS_DUR,
            `FTPU_OFS_HIGH, `FTPU_OFS_CHCFG, `FTPU_OFS_USER, 8'h1c};
        logic [31:0] e_t[7] = '{32'h6, 32'h0, 32'h32, 32'h0, 32'h290, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, a_t[i], 32'h0);
            check("reg_reset", rdat, e_t[i]);
        end
        wb(1'b1, `FTPU_OFS_HIGH, 32'h3);
        wb(1'b0, `FTPU_OFS_HIGH, 32'h0);
        check("high_bits", rdat, 32'h3);
        wb(1'b1, `FTPU_OFS_HIGH, 32'h0);
        check("drive_lo", 32'(lo), 32'h2);
        check("drive_hi", 32'(hi), 32'h0);
    endtask

    task automatic t_static();
        for (int l = 0; l < 2; l++) begin
            wb(1'b1, `FTPU_OFS_CTRL, l ? 32'h0 : 32'h2);
            idle_lvl <= l[0];
            tick(6);
            check("static_idle", 32'(lamp_on), 32'h0);
            trig(n);
            check("static_lat", 32'(n <= 6), 32'h1);
            wait_lamp(1'b0, w);
            check("static_w", w, 125);
        end
        wb(1'b1, `FTPU_OFS_CTRL, 32'h7);
        idle_lvl <= 1'b0;
        tick(6);
    endtask

    task automatic t_pulse(input logic [31:0] ctrl);
        int lo_b;
        lo_b = ctrl[2] ? 3 : 128;
        wb(1'b1, `FTPU_OFS_CTRL, ctrl);
        wb(1'b1, `FTPU_OFS_DUR, 32'hc8);
        tick(4);
        trig(n);
        check("edge_lat", 32'(n >= lo_b && n <= lo_b + 3), 32'h1);
        check("green", 32'(green), 32'h1);
        tick(30);
        check("yellow", 32'({green, yellow}), 32'h1);
        check("ch2_sync", 32'(hi[1]), 32'h1);
        wb(1'b0, `FTPU_OFS_STAT, 32'h0);
        check("sense", 32'(rdat[1]), 32'h1);
        tick(100);
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        wait_lamp(1'b0, w);
        w = w + 138;
        check("flash_w", 32'(w >= 490 && w <= 510), 32'h1);
        tick(300);
        check("retrig", 32'(lamp_on), 32'h0);
    endtask

    task automatic t_delay();
        int n0;
        wb(1'b1, `FTPU_OFS_CTRL, 32'h7);
        wb(1'b1, `FTPU_OFS_DUR, 32'h0);
        trig(n0);
        check("zero_delay", 32'(n0 >= 3 && n0 <= 6), 32'h1);
        wait_lamp(1'b0, w);
        check("min_dur", 32'(w >= 124 && w <= 126), 32'h1);
        tick(10);
        wb(1'b1, `FTPU_OFS_DELAY, 32'h19);
        trig(n);
        check("delay", 32'(n - n0 >= 61 && n - n0 <= 64), 32'h1);
        wait_lamp(1'b0, w);
        check("one_flash", 32'(w >= 124 && w <= 126), 32'h1);
        wb(1'b1, `FTPU_OFS_DELAY, 32'h0);
    endtask

    task automatic t_fast();
        wb(1'b1, `FTPU_OFS_CHCFG, 32'h7290);
        wb(1'b0, `FTPU_OFS_CHCFG, 32'h0);
        check("fast_bits", rdat, 32'h2290);
        tick(4);
        trig(n);
        tick(10);
        check("fast_drive", 32'({hi[1], lo[1]}), 32'h1);
        wait_lamp(1'b0, w);
        tick(3);
        check("fast_idle", 32'(lo[1]), 32'h0);
        wb(1'b1, `FTPU_OFS_CHCFG, 32'h290);
    endtask

    task automatic t_user();
        wb(1'b1, `FTPU_OFS_USER, 32'h4);
        tick(3);
        check("user_on", 32'(lo[2]), 32'h1);
        wb(1'b1, `FTPU_OFS_CHCFG, 32'h690);
        tick(3);
        check("user_source", 32'({hi[2], lo[2]}), 32'h2);
        wb(1'b1, `FTPU_OFS_CHCFG, 32'h290);
        wb(1'b1, `FTPU_OFS_USER, 32'h0);
        tick(3);
        check("user_off", 32'(lo[2]), 32'h0);
    endtask

    task automatic t_fault();
        wb(1'b1, `FTPU_OFS_CTRL, 32'h0);
        tick(6);
        supply_fault <= 1'b1;
        tick(3);
        check("fault", 32'({fault_active, status_red, lamp_on}), 32'h6);
        check("ch1_fault", 32'(lo[0]), 32'h1);
        wb(1'b0, `FTPU_OFS_STAT, 32'h0);
        check("err_supply", 32'(rdat[11:8]), 32'h1);
        supply_fault <= 1'b0;
        tick(4);
        check("recover", 32'({fault_active, lamp_on}), 32'h1);
        chan_fault <= 3'h4;
        tick(3);
        wb(1'b0, `FTPU_OFS_STAT, 32'h0);
        check("err_chan", 32'({rdat[3], rdat[11:8]}), 32'h18);
        chan_fault <= 3'h0;
        tick(4);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        t_reset();
        t_static();
        t_pulse(32'h7);
        t_pulse(32'h3);
        t_delay();
        t_fast();
        t_user();
        t_fault();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule

`default_nettype wire
